// [rtl/vam_pkg.sv]
// shared constants and types for the video alpha mixer
package vam_pkg;
    localparam int PIX_W = 12;
    localparam int OUT_W = 13;
    localparam int DLY_W = 15;
    localparam int FLD_W = 3;
    localparam int PROD_W = 26;

    // weight of exactly one: bit 11 integer, bits 10..0 fraction
    localparam logic [11:0] WEIGHT_ONE = 12'h800;

    // delay field positions inside the delay setting
    localparam int FLD_FIRST_LSB = 0;
    localparam int FLD_SECOND_LSB = 3;
    localparam int FLD_WEIGHT_LSB = 6;
    localparam int FLD_FMT_LSB = 9;
    localparam int FLD_RND_LSB = 12;

    // rounding codes
    localparam logic [1:0] RND_8 = 2'h0;
    localparam logic [1:0] RND_10 = 2'h1;
    localparam logic [1:0] RND_12 = 2'h2;
    localparam logic [1:0] RND_13 = 2'h3;
    localparam logic [12:0] HALF_8 = 13'h0010;
    localparam logic [12:0] HALF_10 = 13'h0004;
    localparam logic [12:0] HALF_12 = 13'h0001;
    localparam logic [12:0] HALF_13 = 13'h0000;
    localparam logic [12:0] KEEP_8 = 13'h1fe0;
    localparam logic [12:0] KEEP_10 = 13'h1ff8;
    localparam logic [12:0] KEEP_12 = 13'h1ffe;
    localparam logic [12:0] KEEP_13 = 13'h1fff;

    // sum bits kept by the adjust stage (one left shift)
    localparam int ADJ_MSB = 22;
    localparam int ADJ_LSB = 10;

    // wishbone register map, byte addresses
    localparam logic [7:0] ADR_CTRL = 8'h00;
    localparam logic [7:0] ADR_DELAY = 8'h04;
    localparam logic [7:0] ADR_OUT = 8'h08;
    localparam int CTRL_BYPASS_BIT = 0;
    localparam int CTRL_OE_N_BIT = 1;
    localparam logic [1:0] CTRL_RST = 2'h2;
    localparam logic [14:0] DELAY_RST = 15'h0000;
    localparam logic [12:0] OUT_RST = 13'h0000;

    typedef struct packed {
        logic [11:0] first;
        logic [11:0] second;
        logic [11:0] weight;
        logic fmt_n;
        logic [1:0] rnd;
    } vam_sample_type;
endpackage

// [rtl/vam_delay_line.sv]
// programmable 0..7 stage delay line
`timescale 1ns/1ns
module vam_delay_line #(
    parameter int W = 12
) (
    input wire logic clk,
    input wire logic rstn,
    input wire logic [W-1:0] din,
    input wire logic [2:0] sel,
    output logic [W-1:0] dout
);
    logic [W-1:0] tap_r [0:6];

    always_ff @(posedge clk) begin
        if (!rstn) begin
            for (int i = 0; i < 7; i++) begin
                tap_r[i] <= '0;
            end
        end else begin
            tap_r[0] <= din;
            for (int i = 1; i < 7; i++) begin
                tap_r[i] <= tap_r[i-1];
            end
        end
    end

    // zero stages passes the captured value straight on
    assign dout = (sel == 3'h0) ? din : tap_r[sel - 3'h1];
endmodule

// [rtl/vam_round.sv]
// output rounding to 8, 10, 12 or 13 bits
`timescale 1ns/1ns
module vam_round (
    input wire logic [12:0] val,
    input wire logic [1:0] rnd,
    output logic [12:0] rounded
);
    logic [12:0] half;
    logic [12:0] keep;

    assign half = (rnd == vam_pkg::RND_8) ? vam_pkg::HALF_8 :
                  (rnd == vam_pkg::RND_10) ? vam_pkg::HALF_10 :
                  (rnd == vam_pkg::RND_12) ? vam_pkg::HALF_12 :
                  vam_pkg::HALF_13;
    assign keep = (rnd == vam_pkg::RND_8) ? vam_pkg::KEEP_8 :
                  (rnd == vam_pkg::RND_10) ? vam_pkg::KEEP_10 :
                  (rnd == vam_pkg::RND_12) ? vam_pkg::KEEP_12 :
                  vam_pkg::KEEP_13;
    // wraps on overflow at the top of the range, no saturation
    assign rounded = (val + half) & keep;
endmodule

// [rtl/vam_mixer.sv]
// video alpha mixer top with wishbone control registers
//
// Functional notes
// - round code selects 8/10/12/13 output bits
// - both pixels captured on rising clock
// - format select high unsigned, low signed
// - format change affects only newly captured samples
// - output is first*weight plus second*(1-weight)
// - weight is unsigned fraction zero to one
// - load enable high captures weight, else hold
// - 15-bit delay setting, five 3-bit fields
// - field value gives 0..7 extra stages
// - delay setting shifted in bit zero first
// - delay data sampled on strobe rising edge
// - bypass forces delay setting to zero
// - sum shifted left one, top bit dropped
// - round code travels with its sample
// - weight above one clamped to one
// - add half below lsb, clear lower bits
// - output driven only while enable low
// - master clock never writes delay setting; here clk loads it on the synchronized strobe rise and clears it on bypass
//
// Register access over Wishbone and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ns
module vam_mixer (
    input wire logic clk,
    input wire logic rstn,
    input wire logic [11:0] pixel_in_first,
    input wire logic [11:0] pixel_in_second,
    input wire logic [11:0] weight_in,
    input wire logic weight_load_enable,
    input wire logic format_select_n,
    input wire logic [1:0] round_select,
    input wire logic delay_serial_data,
    input wire logic delay_load_strobe_n,
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [7:0] adr_i,
    input wire logic [3:0] sel_i,
    input wire logic [31:0] dat_i,
    output logic [31:0] dat_o,
    output logic ack_o,
    output logic [12:0] mixed_out,
    output logic mixed_out_oe
);
    // ---- input capture ----
    vam_pkg::vam_sample_type cap_r;
    vam_pkg::vam_sample_type cap_nxt;

    assign cap_nxt.first = pixel_in_first;
    assign cap_nxt.second = pixel_in_second;
    assign cap_nxt.fmt_n = format_select_n;
    assign cap_nxt.rnd = round_select;
    assign cap_nxt.weight = weight_load_enable ? weight_in :
                            cap_r.weight;

    always_ff @(posedge clk) begin
        if (!rstn) begin
            cap_r <= '0;
        end else begin
            cap_r <= cap_nxt;
        end
    end

    // ---- delay setting, loaded by strobe ----
    // the strobe is asynchronous to clk; data and strobe share
    // the same two-stage path so they stay aligned
    logic ld_s1_r;
    logic ld_s2_r;
    logic ld_s3_r;
    logic del_s1_r;
    logic del_s2_r;
    logic [1:0] ctrl_r;
    logic [14:0] delay_setting_r;
    logic [14:0] delay_setting_nxt;
    logic ld_rise;
    logic bypass;

    always_ff @(posedge clk) begin
        if (!rstn) begin
            ld_s1_r <= 1'b1;
            ld_s2_r <= 1'b1;
            ld_s3_r <= 1'b1;
            del_s1_r <= 1'b0;
            del_s2_r <= 1'b0;
        end else begin
            ld_s1_r <= delay_load_strobe_n;
            ld_s2_r <= ld_s1_r;
            ld_s3_r <= ld_s2_r;
            del_s1_r <= delay_serial_data;
            del_s2_r <= del_s1_r;
        end
    end

    assign ld_rise = ld_s2_r & ~ld_s3_r;
    assign bypass = ctrl_r[vam_pkg::CTRL_BYPASS_BIT];

    // new bit enters at the top, so bit zero ends at the bottom
    assign delay_setting_nxt = bypass ? vam_pkg::DELAY_RST :
        ld_rise ? {del_s2_r, delay_setting_r[14:1]} :
        delay_setting_r;

    always_ff @(posedge clk) begin
        if (!rstn) begin
            delay_setting_r <= vam_pkg::DELAY_RST;
        end else begin
            delay_setting_r <= delay_setting_nxt;
        end
    end

    // ---- per-group programmable delays ----
    logic [11:0] dly_first;
    logic [11:0] dly_second;
    logic [11:0] dly_weight;
    logic [0:0] dly_fmt_n;
    logic [1:0] dly_rnd;
    logic [2:0] fld_first;
    logic [2:0] fld_second;
    logic [2:0] fld_weight;
    logic [2:0] fld_fmt;
    logic [2:0] fld_rnd;

    assign fld_first =
        delay_setting_r[vam_pkg::FLD_FIRST_LSB +: vam_pkg::FLD_W];
    assign fld_second =
        delay_setting_r[vam_pkg::FLD_SECOND_LSB +: vam_pkg::FLD_W];
    assign fld_weight =
        delay_setting_r[vam_pkg::FLD_WEIGHT_LSB +: vam_pkg::FLD_W];
    assign fld_fmt =
        delay_setting_r[vam_pkg::FLD_FMT_LSB +: vam_pkg::FLD_W];
    assign fld_rnd =
        delay_setting_r[vam_pkg::FLD_RND_LSB +: vam_pkg::FLD_W];

    vam_delay_line #(.W(12)) u_dly_first (
        .clk(clk),
        .rstn(rstn),
        .din(cap_r.first),
        .sel(fld_first),
        .dout(dly_first)
    );
    vam_delay_line #(.W(12)) u_dly_second (
        .clk(clk),
        .rstn(rstn),
        .din(cap_r.second),
        .sel(fld_second),
        .dout(dly_second)
    );
    vam_delay_line #(.W(12)) u_dly_weight (
        .clk(clk),
        .rstn(rstn),
        .din(cap_r.weight),
        .sel(fld_weight),
        .dout(dly_weight)
    );
    vam_delay_line #(.W(1)) u_dly_fmt (
        .clk(clk),
        .rstn(rstn),
        .din(cap_r.fmt_n),
        .sel(fld_fmt),
        .dout(dly_fmt_n)
    );
    vam_delay_line #(.W(2)) u_dly_rnd (
        .clk(clk),
        .rstn(rstn),
        .din(cap_r.rnd),
        .sel(fld_rnd),
        .dout(dly_rnd)
    );

    // ---- weight clamp, operand extension, products ----
    logic [11:0] w_clamp;
    logic [11:0] w_comp;
    logic [12:0] a_ext;
    logic [12:0] b_ext;
    logic signed [25:0] prod_a_nxt;
    logic signed [25:0] prod_b_nxt;
    logic signed [25:0] prod_a_r;
    logic signed [25:0] prod_b_r;
    logic [1:0] rnd_s1_r;

    assign w_clamp = (dly_weight > vam_pkg::WEIGHT_ONE) ?
                     vam_pkg::WEIGHT_ONE : dly_weight;
    assign w_comp = vam_pkg::WEIGHT_ONE - w_clamp;
    // unsigned operands get a zero top bit, signed a copy of sign
    assign a_ext = {~dly_fmt_n[0] & dly_first[11], dly_first};
    assign b_ext = {~dly_fmt_n[0] & dly_second[11], dly_second};
    assign prod_a_nxt = $signed(a_ext) * $signed({1'b0, w_clamp});
    assign prod_b_nxt = $signed(b_ext) * $signed({1'b0, w_comp});

    always_ff @(posedge clk) begin
        if (!rstn) begin
            prod_a_r <= '0;
            prod_b_r <= '0;
            rnd_s1_r <= vam_pkg::RND_8;
        end else begin
            prod_a_r <= prod_a_nxt;
            prod_b_r <= prod_b_nxt;
            rnd_s1_r <= dly_rnd;
        end
    end

    // ---- summer and adjust ----
    logic signed [25:0] sum_nxt;
    logic signed [25:0] sum_r;
    logic [1:0] rnd_s2_r;
    logic [12:0] adjusted;
    logic [12:0] rounded;

    assign sum_nxt = prod_a_r + prod_b_r;

    always_ff @(posedge clk) begin
        if (!rstn) begin
            sum_r <= '0;
            rnd_s2_r <= vam_pkg::RND_8;
        end else begin
            sum_r <= sum_nxt;
            rnd_s2_r <= rnd_s1_r;
        end
    end

    // weight never exceeds one, so the summer's top bit is spare
    assign adjusted = sum_r[vam_pkg::ADJ_MSB:vam_pkg::ADJ_LSB];

    vam_round u_round (
        .val(adjusted),
        .rnd(rnd_s2_r),
        .rounded(rounded)
    );

    // ---- output register and enable ----
    logic [12:0] mixed_out_r;
    logic mixed_out_oe_r;

    always_ff @(posedge clk) begin
        if (!rstn) begin
            mixed_out_r <= vam_pkg::OUT_RST;
            mixed_out_oe_r <= 1'b0;
        end else begin
            mixed_out_r <= rounded;
            mixed_out_oe_r <= ~ctrl_r[vam_pkg::CTRL_OE_N_BIT];
        end
    end

    assign mixed_out = mixed_out_r;
    assign mixed_out_oe = mixed_out_oe_r;

    // ---- wishbone slave ----
    logic ack_r;
    logic [31:0] dat_r;
    logic [31:0] rd_nxt;
    logic req;
    logic hit_ctrl;
    logic hit_delay;
    logic hit_out;
    logic wr_ctrl;

    assign req = cyc_i & stb_i & ~ack_r;
    assign hit_ctrl = (adr_i == vam_pkg::ADR_CTRL);
    assign hit_delay = (adr_i == vam_pkg::ADR_DELAY);
    assign hit_out = (adr_i == vam_pkg::ADR_OUT);
    assign wr_ctrl = req & we_i & sel_i[0] & hit_ctrl;
    // unmapped addresses read zero and ignore writes
    assign rd_nxt = hit_ctrl ? {30'h0, ctrl_r} :
                    hit_delay ? {17'h0, delay_setting_r} :
                    hit_out ? {19'h0, mixed_out_r} : 32'h0;

    always_ff @(posedge clk) begin
        if (!rstn) begin
            ctrl_r <= vam_pkg::CTRL_RST;
            ack_r <= 1'b0;
            dat_r <= 32'h0;
        end else begin
            ack_r <= req;
            if (req) begin
                dat_r <= rd_nxt;
            end
            if (wr_ctrl) begin
                ctrl_r <= dat_i[1:0];
            end
        end
    end

    assign ack_o = ack_r;
    assign dat_o = dat_r;

    // ---- checks ----
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);

    weight_hold_a:
        assert property (!weight_load_enable |=> $stable(cap_r.weight))
        else $error("weight changed while load disabled");

    weight_load_a:
        assert property (weight_load_enable |=>
                         cap_r.weight == $past(weight_in))
        else $error("weight not captured while load enabled");

    weight_clamp_a:
        assert property (w_clamp <= vam_pkg::WEIGHT_ONE &&
                         (w_clamp + w_comp) == vam_pkg::WEIGHT_ONE)
        else $error("weight clamp or complement wrong");

    bypass_zero_a:
        assert property (bypass |=> delay_setting_r == 15'h0000)
        else $error("bypass did not clear delay setting");

    delay_shift_a:
        assert property (!ld_s1_r ##1 ld_s1_r ##1 !bypass |=>
                         delay_setting_r[14] == $past(del_s2_r) &&
                         delay_setting_r[13:0] ==
                         $past(delay_setting_r[14:1]))
        else $error("delay bit not shifted in at the top");

    delay_stable_a:
        assert property (!ld_rise && !bypass |=>
                         $stable(delay_setting_r))
        else $error("delay setting changed without strobe");

    unsigned_ext_a:
        assert property (dly_fmt_n[0] |-> !a_ext[12] && !b_ext[12])
        else $error("unsigned operand sign extended");

    equal_mix_a:
        assert property (dly_first == dly_second && dly_fmt_n[0] |=>
                         ##1 adjusted[12:1] == $past(dly_first, 2))
        else $error("equal pixels did not mix to themselves");

    round_clear_a:
        assert property (rnd_s2_r == vam_pkg::RND_8 |=>
                         mixed_out_r[4:0] == 5'h00)
        else $error("8-bit rounding left low bits set");

    round_ten_a:
        assert property (rnd_s2_r == vam_pkg::RND_10 |=>
                         mixed_out_r[2:0] == 3'h0)
        else $error("10-bit rounding left low bits set");

    out_enable_a:
        assert property (ctrl_r[vam_pkg::CTRL_OE_N_BIT] |=>
                         !mixed_out_oe_r)
        else $error("output driven while enable high");

    wb_ack_a:
        assert property (cyc_i && stb_i && !ack_r |=> ack_r ##1 !ack_r)
        else $error("wishbone ack not single cycle");

    bypass_seen_c: cover property (bypass ##1 delay_setting_r == 15'h0);
    strobe_seen_c: cover property (ld_rise && !bypass);
    clamp_seen_c: cover property (dly_weight > vam_pkg::WEIGHT_ONE);
    signed_mix_c: cover property (!dly_fmt_n[0] && dly_first[11]);
endmodule

// [tb/vam_out_bus.sv]
// downstream model of the mixed output bus with three-state resolution
`timescale 1ns/1ns
module vam_out_bus (
    input wire logic clk,
    input wire logic [12:0] mixed_out,
    input wire logic mixed_out_oe,
    output logic [12:0] bus_level
);
    logic [12:0] last_r;

    // released bus shows the inverse of the last driven value, so stale
    // data can never pass for a fresh result
    always_ff @(posedge clk) begin
        if (mixed_out_oe) begin
            last_r <= mixed_out;
        end
    end

    assign bus_level = mixed_out_oe ? mixed_out : ~last_r;
endmodule

// [tb/vam_mixer_tb_top.sv]
// self-checking random bench for the video alpha mixer
`timescale 1ns/1ns
module vam_mixer_tb_top;
    logic clk, rstn, weight_load_enable, format_select_n;
    logic [11:0] pixel_in_first, pixel_in_second, weight_in;
    logic [1:0] round_select;
    logic delay_serial_data, delay_load_strobe_n, cyc_i, stb_i, we_i;
    logic [7:0] adr_i;
    logic [3:0] sel_i;
    logic [31:0] dat_i, dat_o, rd;
    logic ack_o, mixed_out_oe;
    logic [12:0] mixed_out, bus_level;
    logic [12:0] hist [0:255];
    logic [11:0] w_held;
    logic [31:0] seed;
    int fails, checks_done;

    vam_mixer vam_mixer_inst (.clk(clk), .rstn(rstn),
        .pixel_in_first(pixel_in_first), .pixel_in_second(pixel_in_second),
        .weight_in(weight_in), .weight_load_enable(weight_load_enable),
        .format_select_n(format_select_n), .round_select(round_select),
        .delay_serial_data(delay_serial_data),
        .delay_load_strobe_n(delay_load_strobe_n), .cyc_i(cyc_i),
        .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i),
        .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o), .mixed_out(mixed_out),
        .mixed_out_oe(mixed_out_oe));

    vam_out_bus vam_out_bus_inst (.clk(clk), .mixed_out(mixed_out),
        .mixed_out_oe(mixed_out_oe), .bus_level(bus_level));

    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    function automatic logic [31:0] lfsr_next(logic [31:0] s);
        return s[0] ? ((s >> 1) ^ 32'h80200003) : (s >> 1);
    endfunction

    // result in half pixel units, 13 bits, wrapping like the hardware
    function automatic logic [12:0] exp_mix(logic [11:0] a, logic [11:0] b,
            logic [11:0] w, logic fmt_n, logic [1:0] rnd);
        longint sa, sb, wc, s;
        int drop;
        logic [12:0] v;
        sa = fmt_n ? longint'(a) : longint'($signed(a));
        sb = fmt_n ? longint'(b) : longint'($signed(b));
        wc = (w > 12'h800) ? 2048 : longint'(w);
        s = sa * wc + sb * (2048 - wc);
        v = s[22:10];
        drop = (rnd == 2'h0) ? 5 : (rnd == 2'h1) ? 3 : (rnd == 2'h2) ? 1 : 0;
        if (drop > 0) begin
            v = v + (13'h0001 << (drop - 1));
        end
        return v & (13'h1fff << drop);
    endfunction

    task automatic check(logic [31:0] seen, logic [31:0] want, string what);
        checks_done++;
        if (seen !== want) begin
            fails++;
            $display("[FAIL] %0t %s seen %h want %h", $time, what, seen, want);
        end
    endtask

    task automatic wrap_up();
        if (fails == 0 && checks_done > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    task automatic wb(logic we, logic [7:0] adr, logic [31:0] wd);
        int k;
        @(posedge clk);
        cyc_i <= 1'b1;
        stb_i <= 1'b1;
        we_i <= we;
        adr_i <= adr;
        dat_i <= wd;
        for (k = 0; k < 20; k++) begin
            @(posedge clk);
            if (ack_o === 1'b1) break;
        end
        rd = dat_o;
        cyc_i <= 1'b0;
        stb_i <= 1'b0;
        we_i <= 1'b0;
        if (k == 20) begin
            check(32'h0, 32'h1, "bus timeout");
            wrap_up();
        end
    endtask

    task automatic load_delay(logic [14:0] v);
        int i;
        for (i = 0; i < 15; i++) begin
            @(posedge clk);
            delay_serial_data <= v[i];
            @(posedge clk);
            delay_load_strobe_n <= 1'b0;
            repeat (3) @(posedge clk);
            delay_load_strobe_n <= 1'b1;
            repeat (4) @(posedge clk);
        end
        repeat (4) @(posedge clk);
    endtask

    // random stream with corner weights; lat counts edges to the output
    task automatic stream(int n, int lat, logic free_load);
        int i;
        logic [11:0] a, b, w;
        logic ld, f;
        logic [1:0] r;
        for (i = 0; i < n + lat + 1; i++) begin
            @(posedge clk);
            if (i >= lat + 1) check(bus_level, hist[i-lat-1], "mix");
            if (i < n) begin
                seed = lfsr_next(seed);
                a = seed[11:0];
                b = seed[23:12];
                ld = (i == 0) || !free_load || seed[24];
                f = seed[25];
                r = seed[27:26];
                seed = lfsr_next(seed);
                w = seed[11:0];
                if (i % 4 == 3) begin
                    w = (seed[13:12] == 2'h0) ? 12'h000 :
                        (seed[13:12] == 2'h1) ? 12'h800 :
                        (seed[13:12] == 2'h2) ? 12'hfff : 12'h801;
                end
                pixel_in_first <= a;
                pixel_in_second <= b;
                weight_in <= w;
                weight_load_enable <= ld;
                format_select_n <= f;
                round_select <= r;
                if (ld) begin
                    w_held = w;
                end
                hist[i] = exp_mix(a, b, w_held, f, r);
            end
        end
    endtask

    initial begin
        {pixel_in_first, pixel_in_second, weight_in} = '0;
        {weight_load_enable, format_select_n, round_select} = '0;
        {delay_serial_data, cyc_i, stb_i, we_i, adr_i, dat_i} = '0;
        delay_load_strobe_n = 1'b1;
        sel_i = 4'hf;
        rstn = 1'b0;
        seed = 32'd80346;
        fails = 0;
        checks_done = 0;
        repeat (8) @(posedge clk);
        rstn <= 1'b1;
        wb(1'b0, vam_pkg::ADR_CTRL, 32'h0);
        check(rd, 32'h2, "ctrl reset");
        wb(1'b0, vam_pkg::ADR_DELAY, 32'h0);
        check(rd, 32'h0, "delay reset");
        check(mixed_out_oe, 1'b0, "oe at reset");
        wb(1'b1, vam_pkg::ADR_CTRL, 32'h0);
        repeat (2) @(posedge clk);
        check(mixed_out_oe, 1'b1, "oe on");
        stream(200, 4, 1'b1);
        wb(1'b0, vam_pkg::ADR_OUT, 32'h0);
        check(rd, {19'h0, hist[199]}, "out reg");
        wb(1'b0, 8'h0c, 32'h0);
        check(rd, 32'h0, "unmapped");
        wb(1'b1, vam_pkg::ADR_DELAY, 32'h7fff);
        wb(1'b0, vam_pkg::ADR_DELAY, 32'h0);
        check(rd, 32'h0, "delay ro");
        load_delay(15'h4ac5);
        wb(1'b0, vam_pkg::ADR_DELAY, 32'h0);
        check(rd, 32'h4ac5, "delay order");
        load_delay(15'h2492);
        wb(1'b0, vam_pkg::ADR_DELAY, 32'h0);
        check(rd, 32'h2492, "delay fields");
        stream(100, 6, 1'b0);
        wb(1'b1, vam_pkg::ADR_CTRL, 32'h1);
        wb(1'b0, vam_pkg::ADR_DELAY, 32'h0);
        check(rd, 32'h0, "bypass");
        stream(60, 4, 1'b1);
        wb(1'b1, vam_pkg::ADR_CTRL, 32'h2);
        repeat (2) @(posedge clk);
        check(mixed_out_oe, 1'b0, "oe off");
        wrap_up();
    end
endmodule
